// [rtl/trt_timer_top.sv]
/*
  16-bit timer/counter with period match, prescaler, gated accumulation
  and real-time clock use, behind an APB slave.
  Assumes pclk is the instruction clock at 100 MHz, cpu_idle and
  cpu_sleep come from logic on pclk, and the pin and low-power oscillator
  inputs are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
module trt_timer_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor power state
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  // pins
  input wire logic ext_clock_gate_pin,
  input wire logic lp_osc_out,
  // events
  output logic timer_irq,
  output logic wake_event
);

  trt_pkg::trt_ctrl_type timer_control;
  logic [15:0] timer_count;
  logic [15:0] timer_period;
  logic [7:0] pre_cnt;
  logic low_power_osc_enable;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [1:0] ext_sync;
  logic [1:0] lp_sync;
  logic ext_prev;
  logic lp_prev;
  logic bus_write;
  logic wr_count;
  logic wr_period;
  logic wr_control;
  logic wr_status;
  logic wr_mask;
  logic wr_osc;
  logic addr_hit;
  logic [31:0] next_prdata;
  logic normal_mode;
  logic rtc_mode;
  logic gated_mode;
  logic src_event;
  logic hold_count;
  logic count_event;
  logic pre_done;
  logic pre_clear;
  logic cnt_tick;
  logic period_hit;
  logic gate_fall;
  logic [1:0] next_status;

  // two flip-flops on each asynchronous input, then an edge history flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync <= 2'h0;
      lp_sync <= 2'h0;
      ext_prev <= 1'b0;
      lp_prev <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[0], ext_clock_gate_pin};
      lp_sync <= {lp_sync[0], lp_osc_out};
      ext_prev <= ext_sync[1];
      lp_prev <= lp_sync[1];
    end
  end

  // apb decode: a write takes effect at the edge where pready is high
  assign bus_write = psel && penable && pready && pwrite;

  always_comb begin
    wr_count = 1'b0;
    wr_period = 1'b0;
    wr_control = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    wr_osc = 1'b0;
    addr_hit = 1'b1;
    next_prdata = 32'h0000_0000;
    if (paddr == trt_pkg::ADDR_COUNT) begin
      wr_count = bus_write;
      next_prdata[15:0] = timer_count;
    end else if (paddr == trt_pkg::ADDR_PERIOD) begin
      wr_period = bus_write;
      next_prdata[15:0] = timer_period;
    end else if (paddr == trt_pkg::ADDR_CONTROL) begin
      wr_control = bus_write;
      next_prdata[15:0] = trt_pkg::word_from_ctrl(timer_control);
    end else if (paddr == trt_pkg::ADDR_STATUS) begin
      wr_status = bus_write;
      next_prdata[1:0] = irq_status;
    end else if (paddr == trt_pkg::ADDR_MASK) begin
      wr_mask = bus_write;
      next_prdata[1:0] = irq_mask;
    end else if (paddr == trt_pkg::ADDR_OSC) begin
      wr_osc = bus_write;
      next_prdata[trt_pkg::OSC_LP_BIT] = low_power_osc_enable;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // one wait state: pready, read data and error come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= next_prdata;
        pslverr <= !addr_hit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // mode selection
  assign normal_mode = timer_control.timer_run_enable && !low_power_osc_enable;
  assign rtc_mode = low_power_osc_enable && timer_control.timer_run_enable &&
                    timer_control.clock_source_select &&
                    !timer_control.gate_accumulate_enable;
  assign gated_mode = normal_mode && !timer_control.clock_source_select &&
                      timer_control.gate_accumulate_enable;

  // prescaler input event per mode
  always_comb begin
    src_event = 1'b0;
    if (rtc_mode) begin
      src_event = lp_sync[1] && !lp_prev;
    end else if (normal_mode && !timer_control.clock_source_select) begin
      src_event = gated_mode ? ext_sync[1] : 1'b1;
    end else if (normal_mode) begin
      src_event = ext_sync[1] && !ext_prev;
    end
  end

  // idle and sleep hold; only run, external and async select survive sleep
  assign hold_count = (cpu_idle && timer_control.idle_stop_bit) ||
                      (cpu_sleep && !(timer_control.timer_run_enable &&
                       timer_control.clock_source_select &&
                       !timer_control.ext_clock_sync_select));
  assign count_event = src_event && !hold_count;

  assign pre_done = pre_cnt == trt_pkg::pre_end(timer_control.prescale_select);
  assign pre_clear = (wr_count || wr_control) && timer_control.timer_run_enable;
  assign cnt_tick = count_event && pre_done;
  assign period_hit = cnt_tick && (timer_count == timer_period);
  assign gate_fall = gated_mode && ext_prev && !ext_sync[1];

  // prescaler count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 8'h00;
    end else if (pre_clear) begin
      pre_cnt <= 8'h00;
    end else if (count_event) begin
      pre_cnt <= pre_done ? 8'h00 : 8'(pre_cnt + 8'h01);
    end
  end

  // main count; gate fall leaves it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count <= trt_pkg::COUNT_RST;
    end else if (wr_count) begin
      timer_count <= pwdata[15:0];
    end else if (period_hit) begin
      timer_count <= 16'h0000;
    end else if (cnt_tick) begin
      timer_count <= 16'(timer_count + 16'h0001);
    end
  end

  // period, control, oscillator enable and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_period <= trt_pkg::PERIOD_RST;
      timer_control <= trt_pkg::CTRL_RST;
      low_power_osc_enable <= 1'b0;
      irq_mask <= trt_pkg::MASK_RST;
    end else begin
      if (wr_period) begin
        timer_period <= pwdata[15:0];
      end
      if (wr_control) begin
        timer_control <= trt_pkg::ctrl_from_word(pwdata[15:0]);
      end
      if (wr_osc) begin
        low_power_osc_enable <= pwdata[trt_pkg::OSC_LP_BIT];
      end
      if (wr_mask) begin
        irq_mask <= pwdata[1:0];
      end
    end
  end

  // sticky flags: write one to clear, a new event wins over the clear
  always_comb begin
    next_status = irq_status;
    if (wr_status) begin
      next_status = irq_status & ~pwdata[1:0];
    end
    if (period_hit) begin
      next_status[trt_pkg::ST_MATCH_BIT] = 1'b1;
    end
    if (gate_fall) begin
      next_status[trt_pkg::ST_GATE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= trt_pkg::STATUS_RST;
    end else begin
      irq_status <= next_status;
    end
  end

  // interrupt level and carry-out wake pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq <= 1'b0;
      wake_event <= 1'b0;
    end else begin
      timer_irq <= |(irq_status & irq_mask);
      wake_event <= period_hit && rtc_mode;
    end
  end

  // checks on the counting path
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_count_advance: assert property (
    cnt_tick && !wr_count && timer_count != timer_period
    |=> timer_count == 16'($past(timer_count) + 16'h0001))
    else $error("count did not advance by one");

  a_count_wrap: assert property (
    cnt_tick && !wr_count && timer_count == timer_period |=> timer_count == 16'h0000)
    else $error("count did not wrap at period");

  a_idle_stop: assert property (
    cpu_idle && timer_control.idle_stop_bit |-> !cnt_tick && !count_event)
    else $error("counting during idle with idle stop");

  a_idle_runs: assert property (
    cpu_idle && !cpu_sleep && !timer_control.idle_stop_bit && normal_mode &&
    !timer_control.clock_source_select && !gated_mode |-> count_event)
    else $error("internal timer stalled in idle");

  a_gate_low_hold: assert property (
    gated_mode && !ext_sync[1] && !wr_count |=> timer_count == $past(timer_count))
    else $error("gated count moved with gate low");

  a_pre_ratio: assert property (
    cnt_tick && timer_control.prescale_select == 2'h2 |-> pre_cnt == trt_pkg::PRE_END_64)
    else $error("prescaler tick at wrong count");

  a_pre_clear: assert property (
    (wr_count || wr_control) && timer_control.timer_run_enable |=> pre_cnt == 8'h00)
    else $error("prescaler not cleared by write");

  a_pre_kept_off: assert property (
    wr_count && !timer_control.timer_run_enable |=> $stable(pre_cnt))
    else $error("disabled prescaler changed");

  a_ctl_keeps_count: assert property (
    wr_control && !wr_count && !cnt_tick |=> $stable(timer_count))
    else $error("control write changed count");

  a_sleep_stop: assert property (
    cpu_sleep && timer_control.ext_clock_sync_select |-> !cnt_tick)
    else $error("synchronous count ran in sleep");

  a_match_flag: assert property (
    period_hit |=> irq_status[0] ##1 (timer_irq == irq_mask[0] || irq_status[1]))
    else $error("match flag or interrupt wrong");

  a_gate_flag: assert property (
    gate_fall && !wr_count |=> irq_status[1] && $stable(timer_count))
    else $error("gate fall flag missing or count cleared");

  a_lp_disables: assert property (
    low_power_osc_enable && !rtc_mode |-> !src_event)
    else $error("normal mode ran with oscillator enabled");

  // checks on the bus handshake, count sources, prescaler ends, events and the interrupt line
  a_pready_pulse: assert property (
    pready
    |=> !pready)
    else $error("pready held longer than one cycle");

  a_ext_edge_src: assert property (
    normal_mode && timer_control.clock_source_select
    |-> src_event == (ext_sync[1] && !ext_prev))
    else $error("external count event not a rising edge");

  a_async_idle_hold: assert property (
    cpu_idle && timer_control.idle_stop_bit && timer_control.clock_source_select &&
    !timer_control.ext_clock_sync_select && !wr_count
    |=> timer_count == $past(timer_count))
    else $error("asynchronous count moved in idle");

  a_gate_high_counts: assert property (
    gated_mode && ext_sync[1] && !cpu_idle && !cpu_sleep
    |-> count_event)
    else $error("gated count missed a cycle with gate high");

  a_pre_end_eight: assert property (
    cnt_tick && timer_control.prescale_select == 2'h1
    |-> pre_cnt == trt_pkg::PRE_END_8)
    else $error("prescaler 1:8 tick at wrong count");

  a_pre_end_max: assert property (
    cnt_tick && timer_control.prescale_select == 2'h3
    |-> pre_cnt == trt_pkg::PRE_END_256)
    else $error("prescaler 1:256 tick at wrong count");

  a_sleep_async_runs: assert property (
    cpu_sleep && !cpu_idle && normal_mode && timer_control.clock_source_select &&
    !timer_control.ext_clock_sync_select && ext_sync[1] && !ext_prev
    |-> count_event)
    else $error("asynchronous count stalled in sleep");

  a_rtc_edge_counts: assert property (
    rtc_mode && !cpu_idle && !timer_control.ext_clock_sync_select && lp_sync[1] && !lp_prev
    |-> count_event)
    else $error("oscillator edge not counted");

  a_wake_pulse: assert property (
    period_hit && rtc_mode
    |=> wake_event)
    else $error("no wake event on carry");

  a_flag_sticky: assert property (
    irq_status[trt_pkg::ST_MATCH_BIT] && !wr_status
    |=> irq_status[trt_pkg::ST_MATCH_BIT])
    else $error("match flag dropped without a clear");

  a_irq_set: assert property (
    (irq_status & irq_mask) != 2'h0
    |=> timer_irq)
    else $error("interrupt low with unmasked flag");

  a_irq_clear: assert property (
    (irq_status & irq_mask) == 2'h0
    |=> !timer_irq)
    else $error("interrupt high with no unmasked flag");

  a_halt_no_event: assert property (
    !timer_control.timer_run_enable
    |-> !count_event && !pre_clear)
    else $error("stopped timer moved its prescaler");

  c_period_wrap: cover property (period_hit ##1 timer_irq);
  c_gate_fall: cover property (gated_mode ##[1:40] gate_fall);
  c_rtc_wake: cover property (rtc_mode && cpu_sleep && wake_event);
  c_prescale_256: cover property (cnt_tick && timer_control.prescale_select == 2'h3);

endmodule

// [rtl/trt_pkg.sv]
/*
  Package for the 16-bit timer/counter with real-time clock use: register
  indices and bus addresses, control field positions, reset values,
  prescaler end counts, the control word carrier and its helper functions.
  Assumes an APB slave with 32-bit data, one register per aligned word.
*/
package trt_pkg;

  // register indices; the byte address is four times the index
  localparam logic [15:0] IDX_COUNT = 16'h0100;
  localparam logic [15:0] IDX_PERIOD = 16'h0102;
  localparam logic [15:0] IDX_CONTROL = 16'h0104;
  localparam logic [15:0] IDX_STATUS = 16'h0106;
  localparam logic [15:0] IDX_MASK = 16'h0108;
  localparam logic [15:0] IDX_OSC = 16'h010a;

  localparam logic [11:0] ADDR_COUNT = {IDX_COUNT[9:0], 2'b00};
  localparam logic [11:0] ADDR_PERIOD = {IDX_PERIOD[9:0], 2'b00};
  localparam logic [11:0] ADDR_CONTROL = {IDX_CONTROL[9:0], 2'b00};
  localparam logic [11:0] ADDR_STATUS = {IDX_STATUS[9:0], 2'b00};
  localparam logic [11:0] ADDR_MASK = {IDX_MASK[9:0], 2'b00};
  localparam logic [11:0] ADDR_OSC = {IDX_OSC[9:0], 2'b00};

  // control, oscillator and status word field positions
  localparam int CTL_RUN_BIT = 15;
  localparam int CTL_IDLE_BIT = 13;
  localparam int CTL_GATE_BIT = 6;
  localparam int CTL_PS_LSB = 4;
  localparam int CTL_SYNC_BIT = 2;
  localparam int CTL_SRC_BIT = 1;
  localparam int OSC_LP_BIT = 1;
  localparam int ST_MATCH_BIT = 0;
  localparam int ST_GATE_BIT = 1;

  // values after reset
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [1:0] STATUS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;

  // prescaler end counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] PRE_END_1 = 8'h00;
  localparam logic [7:0] PRE_END_8 = 8'h07;
  localparam logic [7:0] PRE_END_64 = 8'h3f;
  localparam logic [7:0] PRE_END_256 = 8'hff;

  typedef struct packed {
    logic timer_run_enable;
    logic idle_stop_bit;
    logic gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic ext_clock_sync_select;
    logic clock_source_select;
  } trt_ctrl_type;

  localparam trt_ctrl_type CTRL_RST = '0;

  // unpack a bus word into control fields
  function automatic trt_ctrl_type ctrl_from_word(input logic [15:0] w);
    trt_ctrl_type c;
    c.timer_run_enable = w[CTL_RUN_BIT];
    c.idle_stop_bit = w[CTL_IDLE_BIT];
    c.gate_accumulate_enable = w[CTL_GATE_BIT];
    c.prescale_select = w[CTL_PS_LSB+:2];
    c.ext_clock_sync_select = w[CTL_SYNC_BIT];
    c.clock_source_select = w[CTL_SRC_BIT];
    return c;
  endfunction

  // pack control fields back into a word, unused bits zero
  function automatic logic [15:0] word_from_ctrl(input trt_ctrl_type c);
    logic [15:0] w;
    w = CONTROL_RST;
    w[CTL_RUN_BIT] = c.timer_run_enable;
    w[CTL_IDLE_BIT] = c.idle_stop_bit;
    w[CTL_GATE_BIT] = c.gate_accumulate_enable;
    w[CTL_PS_LSB+:2] = c.prescale_select;
    w[CTL_SYNC_BIT] = c.ext_clock_sync_select;
    w[CTL_SRC_BIT] = c.clock_source_select;
    return w;
  endfunction

  // last prescaler count before an output tick
  function automatic logic [7:0] pre_end(input logic [1:0] sel);
    logic [7:0] e;
    case (sel)
      2'h0: e = PRE_END_1;
      2'h1: e = PRE_END_8;
      2'h2: e = PRE_END_64;
      default: e = PRE_END_256;
    endcase
    return e;
  endfunction

endpackage

// [verif/trt_pin_model.sv]
/*
  Far-side model of the timer pins: an external clock or gate source and
  a low-power oscillator, each with a tally of the rising edges its bursts made.
  Assumes the bench requests bursts on pclk and waits on the tallies.
*/
`timescale 1ns/1ps
module trt_pin_model #(
  parameter int EXT_HALF = 4,
  parameter int LP_HALF = 1526
) (
  // clock
  input wire logic pclk,
  // requests from the bench
  input wire logic ext_run,
  input wire logic gate_level,
  input wire logic lp_run,
  // pins
  output logic ext_clock_gate_pin,
  output logic lp_osc_out,
  // rising edge tallies
  output int ext_edges,
  output int lp_edges
);
  int ext_div;
  int lp_div;

  // quiet pins at time zero
  initial begin
    ext_clock_gate_pin = 1'b0;
    lp_osc_out = 1'b0;
    ext_edges = 0;
    lp_edges = 0;
    ext_div = 0;
    lp_div = 0;
  end

  // external clock toggles only inside a burst, otherwise shows the gate level
  always @(posedge pclk) begin
    if (ext_run) begin
      ext_div <= (ext_div == EXT_HALF - 1) ? 0 : ext_div + 1;
      if (ext_div == EXT_HALF - 1) begin
        ext_clock_gate_pin <= !ext_clock_gate_pin;
        ext_edges <= ext_edges + (ext_clock_gate_pin ? 0 : 1);
      end
    end else begin
      ext_div <= 0;
      ext_clock_gate_pin <= gate_level;
    end
  end

  // oscillator keeps running through processor sleep while requested
  always @(posedge pclk) begin
    if (lp_run) begin
      lp_div <= (lp_div == LP_HALF - 1) ? 0 : lp_div + 1;
      if (lp_div == LP_HALF - 1) begin
        lp_osc_out <= !lp_osc_out;
        lp_edges <= lp_edges + (lp_osc_out ? 0 : 1);
      end
    end else begin
      lp_div <= 0;
      lp_osc_out <= 1'b0;
    end
  end
endmodule

// [verif/timer_rtc_16bit_tb.sv]
/*
  Self-checking bench for the timer: apb tasks, pin model, integer sums
  of expected ticks compared at every register read.
  Assumes trt_pkg, trt_timer_top and trt_pin_model are compiled first.
*/
`timescale 1ns/1ps
module timer_rtc_16bit_tb;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cpu_idle = 0;
  logic cpu_sleep = 0;
  logic ext_run = 0;
  logic gate_level = 0;
  logic lp_run = 0;
  logic ext_pin;
  logic lp_osc;
  logic timer_irq;
  logic wake_event;
  int ext_edges;
  int lp_edges;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int wakes = 0;
  int tc;
  logic [31:0] seed = 32'h0000_3a0a;
  logic [31:0] rd;
  logic err;

  // clock and cycle / wake tallies
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    wakes <= wakes + ((wake_event === 1'b1) ? 1 : 0);
  end

  trt_timer_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
    .ext_clock_gate_pin(ext_pin), .lp_osc_out(lp_osc), .timer_irq(timer_irq),
    .wake_event(wake_event));

  trt_pin_model i_pins (.pclk(pclk), .ext_run(ext_run), .gate_level(gate_level),
    .lp_run(lp_run), .ext_clock_gate_pin(ext_pin), .lp_osc_out(lp_osc),
    .ext_edges(ext_edges), .lp_edges(lp_edges));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] ctl(input logic run, input logic idl, input logic gt,
                                      input logic [1:0] ps, input logic sy, input logic src);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[trt_pkg::CTL_RUN_BIT] = run;
    w[trt_pkg::CTL_IDLE_BIT] = idl;
    w[trt_pkg::CTL_GATE_BIT] = gt;
    w[trt_pkg::CTL_PS_LSB+:2] = ps;
    w[trt_pkg::CTL_SYNC_BIT] = sy;
    w[trt_pkg::CTL_SRC_BIT] = src;
    return w;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; tc holds the cycle of the completing edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    tc = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #700_000;
    fail_count++;
    conclude();
  end

  initial begin
    int p;
    int t0;
    int t1;
    int tm;
    int dv;
    int g;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped slot
    rdchk(trt_pkg::ADDR_COUNT, 32'h0000_0000);
    rdchk(trt_pkg::ADDR_PERIOD, 32'h0000_ffff);
    rdchk(trt_pkg::ADDR_CONTROL, 32'h0000_0000);
    rdchk(trt_pkg::ADDR_STATUS, 32'h0000_0000);
    rdchk(trt_pkg::ADDR_MASK, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0000);
    rdchk(trt_pkg::ADDR_OSC, 32'h0000_0000);
    rdchk(12'hffc, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    $display("test reset done");
    // internal counting through each prescale, with a control write mid-run
    for (int s = 0; s < 4; s++) begin
      seed = lfsr(seed);
      p = 2 + seed[2:0];
      dv = (s == 0) ? 1 : (s == 1) ? 8 : (s == 2) ? 64 : 256;
      apb(1'b1, trt_pkg::ADDR_PERIOD, 32'(p));
      apb(1'b1, trt_pkg::ADDR_COUNT, 32'h0000_0000);
      apb(1'b1, trt_pkg::ADDR_STATUS, 32'h0000_0003);
      apb(1'b1, trt_pkg::ADDR_CONTROL, ctl(1'b1, 1'b0, 1'b0, s[1:0], 1'b0, 1'b0));
      t0 = tc;
      repeat (dv * (p + 2)) @(posedge pclk);
      apb(1'b1, trt_pkg::ADDR_CONTROL, ctl(1'b1, 1'b0, 1'b0, s[1:0], 1'b0, 1'b0));
      t1 = tc;
      repeat (dv * 2 + seed[4:0]) @(posedge pclk);
      apb(1'b1, trt_pkg::ADDR_CONTROL, 32'h0000_0000);
      tm = (t1 - t0) / dv + (tc - t1) / dv;
      rdchk(trt_pkg::ADDR_COUNT, 32'(tm % (p + 1)));
      rdchk(trt_pkg::ADDR_STATUS, 32'h0000_0001);
    end
    // interrupt level follows flag and mask, flag clears on a written one
    chk({31'h0, timer_irq}, 32'h0000_0000);
    apb(1'b1, trt_pkg::ADDR_MASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk({31'h0, timer_irq}, 32'h0000_0001);
    apb(1'b1, trt_pkg::ADDR_STATUS, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk({31'h0, timer_irq}, 32'h0000_0000);
    rdchk(trt_pkg::ADDR_STATUS, 32'h0000_0000);
    $display("test prescale done");
    // idle without stop, idle with stop, sleep on internal clock
    apb(1'b1, trt_pkg::ADDR_PERIOD, 32'h0000_ffff);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, trt_pkg::ADDR_COUNT, 32'h0000_0000);
      apb(1'b1, trt_pkg::ADDR_CONTROL, ctl(1'b1, k == 1, 1'b0, 2'h0, 1'b0, 1'b0));
      t0 = tc;
      repeat (20) @(posedge pclk);
      cpu_sleep <= (k == 2);
      cpu_idle <= (k != 2);
      repeat (30) @(posedge pclk);
      cpu_idle <= 1'b0;
      cpu_sleep <= 1'b0;
      repeat (10) @(posedge pclk);
      apb(1'b1, trt_pkg::ADDR_CONTROL, 32'h0000_0000);
      rdchk(trt_pkg::ADDR_COUNT, 32'(tc - t0 - ((k > 0) ? 30 : 0)));
    end
    $display("test idle done");
    // external clock: sync awake, async asleep, sync asleep, async idle-stop
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, trt_pkg::ADDR_COUNT, 32'h0000_0000);
      apb(1'b1, trt_pkg::ADDR_CONTROL, ctl(1'b1, k == 3, 1'b0, 2'h0, !k[0], 1'b1));
      cpu_sleep <= (k == 1 || k == 2);
      cpu_idle <= (k == 3);
      t0 = ext_edges;
      ext_run <= 1'b1;
      while (ext_edges < t0 + 5) @(posedge pclk);
      ext_run <= 1'b0;
      repeat (10) @(posedge pclk);
      cpu_sleep <= 1'b0;
      cpu_idle <= 1'b0;
      apb(1'b1, trt_pkg::ADDR_CONTROL, 32'h0000_0000);
      rdchk(trt_pkg::ADDR_COUNT, (k < 2) ? 32'h0000_0005 : 32'h0000_0000);
    end
    $display("test external done");
    // gated accumulation: count while gate high, hold and flag on its fall
    seed = lfsr(seed);
    g = 20 + seed[3:0];
    apb(1'b1, trt_pkg::ADDR_COUNT, 32'h0000_0000);
    apb(1'b1, trt_pkg::ADDR_CONTROL, ctl(1'b1, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0));
    gate_level <= 1'b1;
    repeat (g) @(posedge pclk);
    gate_level <= 1'b0;
    repeat (12) @(posedge pclk);
    rdchk(trt_pkg::ADDR_COUNT, 32'(g));
    rdchk(trt_pkg::ADDR_STATUS, 32'h0000_0002);
    chk({31'h0, timer_irq}, 32'h0000_0000);
    apb(1'b1, trt_pkg::ADDR_MASK, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    chk({31'h0, timer_irq}, 32'h0000_0001);
    apb(1'b1, trt_pkg::ADDR_CONTROL, 32'h0000_0000);
    $display("test gate done");
    // real-time clock in sleep, external pin toggling must be ignored
    apb(1'b1, trt_pkg::ADDR_PERIOD, 32'h0000_0003);
    apb(1'b1, trt_pkg::ADDR_COUNT, 32'h0000_0000);
    apb(1'b1, trt_pkg::ADDR_OSC, 32'h0000_0002);
    rdchk(trt_pkg::ADDR_OSC, 32'h0000_0002);
    apb(1'b1, trt_pkg::ADDR_CONTROL, ctl(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1));
    cpu_sleep <= 1'b1;
    t0 = wakes;
    lp_run <= 1'b1;
    ext_run <= 1'b1;
    while (lp_edges < 9) @(posedge pclk);
    lp_run <= 1'b0;
    ext_run <= 1'b0;
    repeat (10) @(posedge pclk);
    cpu_sleep <= 1'b0;
    apb(1'b1, trt_pkg::ADDR_CONTROL, 32'h0000_0000);
    rdchk(trt_pkg::ADDR_COUNT, 32'h0000_0001);
    chk(32'(wakes - t0), 32'h0000_0002);
    $display("test rtc done");
    conclude();
  end
endmodule
